// *** logic/scpc_pkg.sv ***
// shared constants for the dual serial channel pin control block
package scpc_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ    = 100_000_000;
	localparam int unsigned BAUD_RATE = 115_200;
	// clocks per serial bit, rounded down
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
	// receive time-out in character times of ten bits
	localparam int unsigned TIMEOUT_CHARS   = 4;
	localparam int unsigned BITS_PER_CHAR   = 10;
	localparam int unsigned TIMEOUT_CYCLES  = TIMEOUT_CHARS * BITS_PER_CHAR * BIT_CYCLES;

	// ****************************************
	// register indices (per channel)
	// ****************************************
	localparam logic [3:0] REG_RXDATA  = 4'h0;
	localparam logic [3:0] REG_TXDATA  = 4'h1;
	localparam logic [3:0] REG_FIFOCTL = 4'h2;
	localparam logic [3:0] REG_CHANCTL = 4'h3;
	localparam logic [3:0] REG_MODEM   = 4'h4;
	localparam logic [3:0] REG_LINE    = 4'h5;
	localparam logic [3:0] REG_MSTAT   = 4'h6;
	localparam logic [3:0] REG_IRQSTAT = 4'h7;
	localparam logic [3:0] REG_IRQMASK = 4'h8;
	// address bit that picks the channel
	localparam int unsigned CHAN_SEL_BIT = 4;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned MCR_DTR  = 0;
	localparam int unsigned MCR_RTS  = 1;
	localparam int unsigned MCR_IRQE = 3;
	localparam int unsigned MCR_LOOP = 4;
	localparam int unsigned FCR_FEN  = 0;
	localparam int unsigned FCR_RCLR = 1;
	localparam int unsigned FCR_TCLR = 2;
	localparam int unsigned FCR_DMA  = 3;
	localparam int unsigned FCR_TRIG = 6;
	localparam int unsigned CTL_TXEN = 0;
	localparam int unsigned CTL_RXEN = 1;
	localparam int unsigned LSR_DR   = 0;
	localparam int unsigned LSR_OE   = 1;
	localparam int unsigned LSR_TX_HOLDING_EMPTY_FLAG = 5;
	localparam int unsigned LSR_TX_ALL_EMPTY_FLAG = 6;
	localparam int unsigned MSR_RING_FALLING_EDGE_FLAG = 2;
	localparam int unsigned MSR_RI   = 6;
	localparam int unsigned IRQ_RXAV = 0;
	localparam int unsigned IRQ_TX_HOLDING_EMPTY_FLAG = 1;
	localparam int unsigned IRQ_RING = 2;
	localparam int unsigned IRQ_OVR  = 3;

	// receive trigger levels selected by the two trigger bits
	localparam logic [4:0] TRIG_LVL0 = 5'h01;
	localparam logic [4:0] TRIG_LVL1 = 5'h04;
	localparam logic [4:0] TRIG_LVL2 = 5'h08;
	localparam logic [4:0] TRIG_LVL3 = 5'h0e;

	// serial frame: start, eight data, stop
	localparam logic [3:0] DATA_BITS = 4'h8;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_START = 3'b010,
		RX_DATA  = 3'b100
	} scpc_rx_state_t;
endpackage

// *** logic/scpc_top.sv ***
// one asynchronous serial channel and the two-channel top around it
`timescale 1ns/10ps

// ****************************************
// channel
// ****************************************
module scpc_channel
	import scpc_pkg::*;
#(
	parameter int unsigned BIT_DIV   = BIT_CYCLES,
	parameter int unsigned DEPTH     = 16,
	parameter int unsigned TO_CYCLES = TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// register port
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rd_val,
	// pins
	input  wire logic       serial_rx_pin,
	input  wire logic       ring_pin,
	output logic            serial_tx_pin,
	output logic            terminal_ready_n,
	output logic            send_request_n,
	output logic            rx_dma_request_n,
	output logic            channel_irq_out,
	output logic            channel_irq_oe
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic                      rx_s1;
		logic                      rx_s2;
		logic                      ri_s1;
		logic                      ri_s2;
		logic                      ri_prev;
		logic [4:0]                mcr;
		logic [7:0]                fcr;
		logic [1:0]                ctl;
		logic [3:0]                imr;
		logic [3:0]                isr;
		logic                      ovr;
		logic                      ring_falling_edge_flag;
		logic [7:0]                tx_hold;
		logic                      tx_holding_empty_flag;
		logic [8:0]                tx_sh;
		logic [3:0]                tx_bits;
		logic [15:0]               tx_cnt;
		logic                      tx_busy;
		logic                      tx_line;
		scpc_rx_state_t            rx_st;
		logic [15:0]               rx_cnt;
		logic [3:0]                rx_bits;
		logic [7:0]                rx_sh;
		logic [DEPTH-1:0][7:0]     mem;
		logic [AW-1:0]             wp;
		logic [AW-1:0]             rp;
		logic [AW:0]               cnt;
		logic [31:0]               to_cnt;
		logic                      sout;
		logic                      dtr_n;
		logic                      rts_n;
		logic                      rdy_n;
		logic                      irq;
		logic                      irq_oe;
	} scpc_chan_t;

	scpc_chan_t r_reg;
	scpc_chan_t r_next;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 16)
			$error("DEPTH must be a power of two from 2 to 16");
		if (BIT_DIV < 4 || BIT_DIV > 65535)
			$error("BIT_DIV out of range");
		if (TO_CYCLES < 1)
			$error("TO_CYCLES must be positive");
	end

	logic          rx_in;
	logic [AW:0]   cap;
	logic [4:0]    trig;
	logic          mode1;
	logic          push;
	logic          pop;

	always_comb begin
		r_next = r_reg;
		// both pin inputs pass two flops first
		r_next.rx_s1   = serial_rx_pin;
		r_next.rx_s2   = r_reg.rx_s1;
		r_next.ri_s1   = ring_pin;
		r_next.ri_s2   = r_reg.ri_s1;
		r_next.ri_prev = r_reg.ri_s2;
		// loop feeds the receiver from the transmitter
		rx_in = r_reg.mcr[MCR_LOOP] ? r_reg.tx_line : r_reg.rx_s2;
		// without fifos the receiver holds a single character
		cap   = r_reg.fcr[FCR_FEN] ? (AW+1)'(DEPTH) : (AW+1)'(1);
		case (r_reg.fcr[FCR_TRIG +: 2])
			2'h0:    trig = TRIG_LVL0;
			2'h1:    trig = TRIG_LVL1;
			2'h2:    trig = TRIG_LVL2;
			default: trig = TRIG_LVL3;
		endcase
		push = 1'b0;
		pop  = rd && addr == REG_RXDATA && r_reg.cnt != '0;

		// read data and read side effects
		case (addr)
			REG_RXDATA:  rd_val = r_reg.mem[r_reg.rp];
			REG_FIFOCTL: rd_val = {r_reg.fcr[7:6], 6'h00};
			REG_CHANCTL: rd_val = {6'h00, r_reg.ctl};
			REG_MODEM:   rd_val = {3'h0, r_reg.mcr};
			REG_LINE: begin
				rd_val = 8'h00;
				rd_val[LSR_DR]   = r_reg.cnt != '0;
				rd_val[LSR_OE]   = r_reg.ovr;
				rd_val[LSR_TX_HOLDING_EMPTY_FLAG] = r_reg.tx_holding_empty_flag;
				rd_val[LSR_TX_ALL_EMPTY_FLAG] = r_reg.tx_holding_empty_flag & ~r_reg.tx_busy;
			end
			REG_MSTAT: begin
				rd_val = 8'h00;
				rd_val[MSR_RI]   = r_reg.ri_s2;
				rd_val[MSR_RING_FALLING_EDGE_FLAG] = r_reg.ring_falling_edge_flag;
			end
			REG_IRQSTAT: rd_val = {4'h0, r_reg.isr};
			REG_IRQMASK: rd_val = {4'h0, r_reg.imr};
			default:     rd_val = 8'h00;
		endcase
		if (pop) begin
			r_next.rp  = r_reg.rp + 1'b1;
			r_next.cnt = r_reg.cnt - 1'b1;
		end
		if (rd && addr == REG_LINE)
			r_next.ovr = 1'b0;
		if (rd && addr == REG_MSTAT)
			r_next.ring_falling_edge_flag = 1'b0;
		if (rd && addr == REG_IRQSTAT)
			r_next.isr = 4'h0;

		// register writes
		if (wr) begin
			case (addr)
				REG_TXDATA: begin
					r_next.tx_hold = wdata;
					r_next.tx_holding_empty_flag    = 1'b0;
				end
				REG_FIFOCTL: begin
					// clear bits act once and are not kept
					r_next.fcr = wdata & 8'hc9;
					if (wdata[FCR_RCLR] || wdata[FCR_FEN] != r_reg.fcr[FCR_FEN]) begin
						r_next.wp  = '0;
						r_next.rp  = '0;
						r_next.cnt = '0;
					end
					if (wdata[FCR_TCLR])
						r_next.tx_holding_empty_flag = 1'b1;
				end
				REG_CHANCTL: r_next.ctl = wdata[1:0];
				REG_MODEM:   r_next.mcr = wdata[4:0];
				REG_IRQMASK: r_next.imr = wdata[3:0];
				default: ;
			endcase
		end

		// ****************************************
		// transmitter
		// ****************************************
		if (!r_reg.ctl[CTL_TXEN]) begin
			// disabling aborts any character in flight
			r_next.tx_busy = 1'b0;
			r_next.tx_line = 1'b1;
		end else if (r_reg.tx_busy) begin
			if (r_reg.tx_cnt == 16'(BIT_DIV - 1)) begin
				r_next.tx_cnt = 16'h0000;
				if (r_reg.tx_bits == 4'h0) begin
					r_next.tx_busy = 1'b0;
				end else begin
					r_next.tx_line = r_reg.tx_sh[0];
					r_next.tx_sh   = {1'b1, r_reg.tx_sh[8:1]};
					r_next.tx_bits = r_reg.tx_bits - 1'b1;
				end
			end else begin
				r_next.tx_cnt = r_reg.tx_cnt + 1'b1;
			end
		end else if (!r_reg.tx_holding_empty_flag) begin
			// start bit is space, stop bit is mark
			r_next.tx_line = 1'b0;
			r_next.tx_sh   = {1'b1, r_reg.tx_hold};
			r_next.tx_bits = DATA_BITS + 4'h1;
			r_next.tx_cnt  = 16'h0000;
			r_next.tx_busy = 1'b1;
			r_next.tx_holding_empty_flag    = 1'b1;
			r_next.isr[IRQ_TX_HOLDING_EMPTY_FLAG] = 1'b1;
		end

		// ****************************************
		// receiver
		// ****************************************
		case (r_reg.rx_st)
			RX_IDLE: begin
				if (r_reg.ctl[CTL_RXEN] && !rx_in) begin
					r_next.rx_st  = RX_START;
					r_next.rx_cnt = 16'h0000;
				end
			end
			RX_START: begin
				if (r_reg.rx_cnt == 16'(BIT_DIV / 2)) begin
					r_next.rx_cnt  = 16'h0000;
					r_next.rx_bits = 4'h0;
					r_next.rx_st   = rx_in ? RX_IDLE : RX_DATA;
				end else begin
					r_next.rx_cnt = r_reg.rx_cnt + 1'b1;
				end
			end
			RX_DATA: begin
				if (r_reg.rx_cnt == 16'(BIT_DIV - 1)) begin
					r_next.rx_cnt = 16'h0000;
					if (r_reg.rx_bits != DATA_BITS) begin
						r_next.rx_sh   = {rx_in, r_reg.rx_sh[7:1]};
						r_next.rx_bits = r_reg.rx_bits + 1'b1;
					end else begin
						r_next.rx_st = RX_IDLE;
						push         = 1'b1;
					end
				end else begin
					r_next.rx_cnt = r_reg.rx_cnt + 1'b1;
				end
			end
			default: r_next.rx_st = RX_IDLE;
		endcase
		if (!r_reg.ctl[CTL_RXEN])
			r_next.rx_st = RX_IDLE;
		if (push) begin
			if (r_next.cnt < cap) begin
				// a receive clear in the same cycle has already rewound the pointer
				r_next.mem[r_next.wp] = r_reg.rx_sh;
				r_next.wp  = r_next.wp + 1'b1;
				r_next.cnt = r_next.cnt + 1'b1;
				r_next.isr[IRQ_RXAV] = 1'b1;
			end else begin
				r_next.ovr = 1'b1;
				r_next.isr[IRQ_OVR] = 1'b1;
			end
		end

		// time-out counts idle time while characters wait
		if (r_next.cnt == '0 || push || pop)
			r_next.to_cnt = 32'h0000_0000;
		else if (r_reg.to_cnt != 32'(TO_CYCLES))
			r_next.to_cnt = r_reg.to_cnt + 1'b1;

		// dma request, active low; the mode follows the control value being registered
		mode1 = r_next.fcr[FCR_FEN] & r_next.fcr[FCR_DMA];
		if (!mode1)
			r_next.rdy_n = r_next.cnt == '0;
		else if (r_next.cnt == '0)
			r_next.rdy_n = 1'b1;
		else if (5'(r_next.cnt) >= trig || r_next.to_cnt == 32'(TO_CYCLES))
			r_next.rdy_n = 1'b0;

		// ring edge flag: setting wins over a status read
		if (r_reg.ri_prev && !r_reg.ri_s2) begin
			r_next.ring_falling_edge_flag = 1'b1;
			r_next.isr[IRQ_RING] = 1'b1;
		end

		// pins
		r_next.sout   = r_next.mcr[MCR_LOOP] | ~r_next.ctl[CTL_TXEN]
			| r_next.tx_line;
		r_next.dtr_n  = ~r_next.mcr[MCR_DTR];
		r_next.rts_n  = ~r_next.mcr[MCR_RTS];
		r_next.irq    = |(r_next.isr & r_next.imr);
		r_next.irq_oe = r_next.mcr[MCR_IRQE];
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			r_reg         <= '0;
			r_reg.tx_holding_empty_flag    <= 1'b1;
			r_reg.tx_line <= 1'b1;
			r_reg.sout    <= 1'b1;
			r_reg.dtr_n   <= 1'b1;
			r_reg.rts_n   <= 1'b1;
			r_reg.rdy_n   <= 1'b1;
			r_reg.rx_st   <= RX_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign serial_tx_pin    = r_reg.sout;
	assign terminal_ready_n = r_reg.dtr_n;
	assign send_request_n   = r_reg.rts_n;
	assign rx_dma_request_n = r_reg.rdy_n;
	assign channel_irq_out  = r_reg.irq;
	assign channel_irq_oe   = r_reg.irq_oe;

	// ****************************************
	// checks
	// ****************************************
	a_reset_pins: assert property (@(posedge CLK) RST |=>
		send_request_n && terminal_ready_n && serial_tx_pin && !channel_irq_oe
		&& r_reg.mcr == 5'h00)
		else $error("pins not idle after reset");
	a_reset_line: assert property (@(posedge CLK) RST |=>
		r_reg.tx_holding_empty_flag && !r_reg.tx_busy && !r_reg.ovr && r_reg.cnt == '0)
		else $error("line status wrong after reset");
	a_rts_write: assert property (@(posedge CLK) disable iff (RST)
		(wr && addr == REG_MODEM) |=> send_request_n == !$past(wdata[MCR_RTS]))
		else $error("send request pin does not follow its bit");
	a_dtr_write: assert property (@(posedge CLK) disable iff (RST)
		(wr && addr == REG_MODEM) |=> terminal_ready_n == !$past(wdata[MCR_DTR]))
		else $error("terminal ready pin does not follow its bit");
	a_loop_mark: assert property (@(posedge CLK) disable iff (RST)
		(r_reg.mcr[MCR_LOOP] || !r_reg.ctl[CTL_TXEN]) |-> serial_tx_pin)
		else $error("serial output not at mark");
	a_mode0_ready: assert property (@(posedge CLK) disable iff (RST)
		!(r_reg.fcr[FCR_FEN] && r_reg.fcr[FCR_DMA]) |->
		rx_dma_request_n == (r_reg.cnt == '0))
		else $error("mode 0 ready does not track held characters");
	a_empty_ready: assert property (@(posedge CLK) disable iff (RST)
		r_reg.cnt == '0 |-> rx_dma_request_n)
		else $error("ready active with empty receiver");
	a_ring_edge: assert property (@(posedge CLK) disable iff (RST)
		(r_reg.ri_prev && !r_reg.ri_s2) |=> r_reg.ring_falling_edge_flag && r_reg.isr[IRQ_RING])
		else $error("ring falling edge not flagged");
	a_ring_level: assert property (@(posedge CLK) disable iff (RST)
		(rd && addr == REG_MSTAT) |-> rd_val[MSR_RI] == r_reg.ri_s2)
		else $error("ring level not in status");
	a_loop_ignore: assert property (@(posedge CLK) disable iff (RST)
		(r_reg.mcr[MCR_LOOP] && r_reg.tx_line && r_reg.rx_st == RX_IDLE)
		|=> r_reg.rx_st == RX_IDLE)
		else $error("receiver started from pin in loop mode");
endmodule

// ****************************************
// two-channel top
// ****************************************
module scpc_top
	import scpc_pkg::*;
#(
	parameter int unsigned BIT_DIV   = BIT_CYCLES,
	parameter int unsigned DEPTH     = 16,
	parameter int unsigned TO_CYCLES = TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// register port
	input  wire logic [4:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	// serial pins, one bit per channel
	input  wire logic [1:0] SERIAL_RX_PIN,
	input  wire logic [1:0] RING_PIN,
	output logic      [1:0] SERIAL_TX_PIN,
	output logic      [1:0] TERMINAL_READY_N,
	output logic      [1:0] SEND_REQUEST_N,
	output logic      [1:0] RX_DMA_REQUEST_N,
	output logic      [1:0] CHANNEL_IRQ_OUT,
	output logic      [1:0] CHANNEL_IRQ_OE
);
	typedef struct packed {
		logic [7:0] rdata;
	} scpc_top_t;

	scpc_top_t  t_reg;
	scpc_top_t  t_next;
	logic [1:0][7:0] rv;
	logic       sel;

	assign sel = ADDR[CHAN_SEL_BIT];

	for (genvar c = 0; c < 2; c++) begin : g_chan
		scpc_channel #(
			.BIT_DIV   (BIT_DIV),
			.DEPTH     (DEPTH),
			.TO_CYCLES (TO_CYCLES)
		) u_chan (
			.CLK              (CLK),
			.RST              (RST),
			.addr             (ADDR[3:0]),
			.wdata            (WDATA),
			.wr               (WR && sel == 1'(c)),
			.rd               (RD && sel == 1'(c)),
			.rd_val           (rv[c]),
			.serial_rx_pin    (SERIAL_RX_PIN[c]),
			.ring_pin         (RING_PIN[c]),
			.serial_tx_pin    (SERIAL_TX_PIN[c]),
			.terminal_ready_n (TERMINAL_READY_N[c]),
			.send_request_n   (SEND_REQUEST_N[c]),
			.rx_dma_request_n (RX_DMA_REQUEST_N[c]),
			.channel_irq_out  (CHANNEL_IRQ_OUT[c]),
			.channel_irq_oe   (CHANNEL_IRQ_OE[c])
		);
	end

	always_comb begin
		t_next       = t_reg;
		t_next.rdata = RD ? rv[sel] : 8'h00;
	end

	always_ff @(posedge CLK) begin
		if (RST)
			t_reg <= '0;
		else
			t_reg <= t_next;
	end

	assign RDATA = t_reg.rdata;
endmodule

// *** tb/scpc_line_model.sv ***
// serial line and ring indicator model standing at the far side of one channel
`timescale 1ns/10ps

module scpc_line_model #(
	parameter int unsigned BIT_DIV = 8
) (
	// clock
	input  wire logic CLK,
	// serial and modem lines
	output logic      line_to_dut,
	output logic      ring_level,
	input  wire logic line_from_dut
);
	// ****************************************
	// sender, ring and capture
	// ****************************************
	initial begin
		line_to_dut = 1'b1; // an idle line rests at mark
		ring_level  = 1'b1;
	end

	// gap gives idle cycles before the frame, so the model can answer promptly or slowly
	task automatic send_char(input logic [7:0] ch, input int unsigned gap);
		logic [9:0] frame;
		frame = {1'b1, ch, 1'b0}; // start is space, data lsb first, stop is mark
		repeat (gap) @(posedge CLK);
		for (int i = 0; i < 10; i++) begin
			@(posedge CLK);
			line_to_dut <= frame[i];
			repeat (BIT_DIV - 1) @(posedge CLK);
		end
	endtask

	task automatic set_ring(input logic v);
		@(posedge CLK);
		ring_level <= v;
		repeat (4) @(posedge CLK);
	endtask

	// bounded wait for a start bit, then centre sampling of each bit
	task automatic get_char(output logic [7:0] ch, output logic ok);
		int n;
		n  = 0;
		ok = 1'b0;
		ch = 8'h00;
		while (line_from_dut !== 1'b0 && n < 40 * BIT_DIV) begin
			@(posedge CLK);
			n++;
		end
		if (line_from_dut === 1'b0) begin
			repeat (BIT_DIV / 2) @(posedge CLK);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_DIV) @(posedge CLK);
				ch[i] = line_from_dut;
			end
			repeat (BIT_DIV) @(posedge CLK);
			ok = (line_from_dut === 1'b1); // stop bit must be mark
		end
	endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the two-channel serial pin control block
`timescale 1ns/10ps

module tb_top;
	import scpc_pkg::*;
	localparam int unsigned BDIV = 8;
	localparam int unsigned TOC  = 400;
	logic        CLK, RST, WR, RD, ok;
	logic [4:0]  ADDR;
	logic [7:0]  WDATA, RDATA, rv, got;
	wire  [1:0]  SERIAL_RX_PIN, RING_PIN;
	logic [1:0]  SERIAL_TX_PIN, TERMINAL_READY_N, SEND_REQUEST_N;
	logic [1:0]  RX_DMA_REQUEST_N, CHANNEL_IRQ_OUT, CHANNEL_IRQ_OE;
	logic [31:0] rng;
	logic [7:0]  sent[$];
	int          errors, checks_done, cycles;

	scpc_top #(.BIT_DIV(BDIV), .DEPTH(4), .TO_CYCLES(TOC)) dut (.CLK(CLK), .RST(RST),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.SERIAL_RX_PIN(SERIAL_RX_PIN), .RING_PIN(RING_PIN), .SERIAL_TX_PIN(SERIAL_TX_PIN),
		.TERMINAL_READY_N(TERMINAL_READY_N), .SEND_REQUEST_N(SEND_REQUEST_N),
		.RX_DMA_REQUEST_N(RX_DMA_REQUEST_N), .CHANNEL_IRQ_OUT(CHANNEL_IRQ_OUT),
		.CHANNEL_IRQ_OE(CHANNEL_IRQ_OE));
	scpc_line_model #(.BIT_DIV(BDIV)) line0 (.CLK(CLK), .line_to_dut(SERIAL_RX_PIN[0]),
		.ring_level(RING_PIN[0]), .line_from_dut(SERIAL_TX_PIN[0]));
	scpc_line_model #(.BIT_DIV(BDIV)) line1 (.CLK(CLK), .line_to_dut(SERIAL_RX_PIN[1]),
		.ring_level(RING_PIN[1]), .line_from_dut(SERIAL_TX_PIN[1]));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] next_rand();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic ch, input logic [3:0] idx, input logic [7:0] d);
		@(posedge CLK);
		ADDR  <= {ch, idx};
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLK);
		WR    <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd_chk(input string what, input logic ch, input logic [3:0] idx,
		input logic [7:0] msk, input logic [7:0] exp);
		@(posedge CLK);
		ADDR <= {ch, idx};
		RD   <= 1'b1;
		@(posedge CLK);
		RD   <= 1'b0;
		#1 chk(what, exp, RDATA & msk);
	endtask

	task automatic pins(input logic [7:0] exp_a, input logic [3:0] exp_b);
		repeat (2) @(posedge CLK);
		#1 chk("rdy_rts_dma_oe", exp_a,
			{TERMINAL_READY_N, SEND_REQUEST_N, RX_DMA_REQUEST_N, CHANNEL_IRQ_OE});
		chk("irq_tx", {4'h0, exp_b}, {4'h0, CHANNEL_IRQ_OUT, SERIAL_TX_PIN});
	endtask

	// sel 0 looks at the channel 0 dma request, sel 1 at its interrupt
	task automatic lvl_chk(input string what, input int sel, input logic exp);
		logic [1:0] v;
		repeat (4) @(posedge CLK);
		#1 v = {CHANNEL_IRQ_OUT[0], RX_DMA_REQUEST_N[0]};
		chk(what, {7'h0, exp}, {7'h0, v[sel]});
	endtask

	task automatic hold_high(input string what, input int ch, input int n);
		logic good;
		good = 1'b1;
		repeat (n) begin
			@(posedge CLK);
			#1 good = good & (SERIAL_TX_PIN[ch] === 1'b1);
		end
		chk(what, 8'h01, {7'h0, good});
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************
	// clock, watchdog and sequence
	// ****************************************
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			$display("[ERR] watchdog expected finish seen hang");
			give_verdict();
		end
	end

	initial begin
		RST = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 5'h00;
		WDATA = 8'h00;
		errors = 0;
		checks_done = 0;
		cycles = 0;
		rng = 32'hefcb;
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		pins(8'hfc, 4'h3);
		rd_chk("line_status0", 1'b0, REG_LINE, 8'hff, 8'h60);
		rd_chk("line_status1", 1'b1, REG_LINE, 8'hff, 8'h60);
		rd_chk("unmapped", 1'b0, 4'hf, 8'hff, 8'h00);
		$display("test reset done");

		wr_reg(1'b1, REG_MODEM, 8'h0b);
		pins(8'h5e, 4'h3);
		wr_reg(1'b0, REG_MODEM, 8'h02);
		pins(8'h4e, 4'h3);
		wr_reg(1'b1, REG_MODEM, 8'h01);
		pins(8'h6c, 4'h3);
		wr_reg(1'b0, REG_CHANCTL, 8'h01);
		wr_reg(1'b0, REG_TXDATA, 8'h00);
		repeat (3 * BDIV) @(posedge CLK);
		RST <= 1'b1;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		pins(8'hfc, 4'h3);
		rd_chk("line_status_rerun", 1'b0, REG_LINE, 8'hff, 8'h60);
		wr_reg(1'b0, REG_TXDATA, 8'h00);
		hold_high("tx_pin_disabled", 0, 12 * BDIV);
		$display("test modem and reset done");

		wr_reg(1'b0, REG_CHANCTL, 8'h02);
		wr_reg(1'b0, REG_FIFOCTL, 8'h08);
		for (int k = 0; k < 3; k++) begin
			rv = next_rand();
			line0.send_char(rv, k);
			lvl_chk("dma_mode0_held", 0, 1'b0);
			rd_chk("rx_data", 1'b0, REG_RXDATA, 8'hff, rv);
			lvl_chk("dma_mode0_empty", 0, 1'b1);
		end
		// single holding slot: a second character before a read is dropped
		rv  = next_rand();
		got = next_rand();
		line0.send_char(rv, 0);
		line0.send_char(got, 0);
		rd_chk("overrun_set", 1'b0, REG_LINE, 8'h03, 8'h03);
		rd_chk("overrun_cleared", 1'b0, REG_LINE, 8'h03, 8'h01);
		rd_chk("overrun_kept", 1'b0, REG_RXDATA, 8'hff, rv);
		wr_reg(1'b0, REG_FIFOCTL, 8'h49);
		for (int k = 0; k < 4; k++) begin
			sent.push_back(next_rand());
			line0.send_char(sent[k], 2 * k);
			lvl_chk("dma_mode1_trigger", 0, k != 3);
		end
		while (sent.size() > 0) begin
			lvl_chk("dma_mode1_draining", 0, 1'b0);
			rd_chk("rx_fifo_data", 1'b0, REG_RXDATA, 8'hff, sent.pop_front());
		end
		lvl_chk("dma_mode1_empty", 0, 1'b1);
		rv = next_rand();
		line0.send_char(rv, 0);
		lvl_chk("dma_before_timeout", 0, 1'b1);
		repeat (TOC) @(posedge CLK);
		lvl_chk("dma_after_timeout", 0, 1'b0);
		rd_chk("rx_timeout_data", 1'b0, REG_RXDATA, 8'hff, rv);
		$display("test receive dma done");

		// drop the character parked while the transmitter was disabled
		wr_reg(1'b0, REG_FIFOCTL, 8'h04);
		wr_reg(1'b0, REG_MODEM, 8'h10);
		wr_reg(1'b0, REG_CHANCTL, 8'h03);
		line0.send_char(next_rand(), 0);
		lvl_chk("loop_ignores_pin", 0, 1'b1);
		rv = next_rand();
		wr_reg(1'b0, REG_TXDATA, rv);
		hold_high("tx_pin_loop", 0, 12 * BDIV);
		lvl_chk("loop_char_held", 0, 1'b0);
		rd_chk("loop_data", 1'b0, REG_RXDATA, 8'hff, rv);
		wr_reg(1'b0, REG_MODEM, 8'h00);
		$display("test loop done");

		wr_reg(1'b1, REG_CHANCTL, 8'h01);
		rv = next_rand();
		fork
			line1.get_char(got, ok);
			wr_reg(1'b1, REG_TXDATA, rv);
		join
		chk("tx_char", rv, got);
		chk("tx_stop", 8'h01, {7'h0, ok});
		hold_high("tx_pin_empty", 1, 4 * BDIV);
		rd_chk("line_status_sent", 1'b1, REG_LINE, 8'h60, 8'h60);
		$display("test transmit done");

		rd_chk("irq_clear", 1'b0, REG_IRQSTAT, 8'hff, 8'h0b);
		rd_chk("ring_high", 1'b0, REG_MSTAT, 8'h44, 8'h40);
		line0.set_ring(1'b0);
		lvl_chk("irq_masked", 1, 1'b0);
		rd_chk("ring_fell", 1'b0, REG_MSTAT, 8'h44, 8'h04);
		rd_chk("ring_edge_cleared", 1'b0, REG_MSTAT, 8'h44, 8'h00);
		rd_chk("irq_ring_sticky", 1'b0, REG_IRQSTAT, 8'hff, 8'h04);
		wr_reg(1'b0, REG_IRQMASK, 8'h04);
		line0.set_ring(1'b1);
		lvl_chk("irq_ring_rise", 1, 1'b0);
		line0.set_ring(1'b0);
		lvl_chk("irq_raised", 1, 1'b1);
		rd_chk("irq_status", 1'b0, REG_IRQSTAT, 8'hff, 8'h04);
		lvl_chk("irq_dropped", 1, 1'b0);
		$display("test ring and interrupt done");
		give_verdict();
	end
endmodule
